// ===== hw/rcf_pkg.sv
// Constants and types shared by the rate-of-change-of-frequency stages
package rcf_pkg;
	localparam int NSTAGE = 8;
	localparam int NGROUP = 8;
	localparam int NREF = 3;
	localparam int LOG_DEPTH = 12;
	// Clock and time base
	localparam int CLK_HZ = 40000000;
	localparam int PROG_CYCLE_MS = 5;
	localparam int STAMP_RES_MS = 1;
	localparam int TICK_CYCLES = CLK_HZ / 1000 * PROG_CYCLE_MS;
	localparam int MS_CYCLES = CLK_HZ / 1000 * STAMP_RES_MS;
	// Settings, slope in 0.01 Hz/s, frequency in 0.01 Hz, delay in 5 ms steps
	localparam logic [15:0] HYST = 16'h000A;
	localparam logic [15:0] MAXRATE_RST = 16'h07D0;
	localparam logic [15:0] PICK_RST = 16'h0014;
	localparam logic [15:0] UFLIM_RST = 16'h1383;
	localparam logic [15:0] OFLIM_RST = 16'h13EC;
	localparam logic [18:0] DLY_RST = 19'h00014;
	localparam logic [18:0] DLY_MAX = 19'h57E40;
	localparam logic [15:0] EN_RST = 16'h5555;
	localparam logic [1:0] EN_YES = 2'h2;
	localparam logic [9:0] RATIO_SCALE = 10'h3E8;
	// Register byte offsets
	localparam logic [7:0] R_CTRL = 8'h00;
	localparam logic [7:0] R_MAXRATE = 8'h04;
	localparam logic [7:0] R_ENABLE = 8'h08;
	localparam logic [7:0] R_FORCE = 8'h0C;
	localparam logic [7:0] R_STATUS = 8'h10;
	localparam logic [7:0] R_CNT_START = 8'h14;
	localparam logic [7:0] R_CNT_TRIP = 8'h18;
	localparam logic [7:0] R_CNT_BLK = 8'h1C;
	localparam logic [7:0] R_RATIO = 8'h20;
	localparam logic [7:0] R_VOLT = 8'h24;
	localparam logic [7:0] R_LOG_SEL = 8'h28;
	localparam logic [7:0] R_LOG_INFO = 8'h2C;
	localparam logic [7:0] R_LOG_TIME = 8'h30;
	localparam logic [7:0] R_GRP_SEL = 8'h40;
	localparam logic [7:0] R_PICK = 8'h44;
	localparam logic [7:0] R_UFLIM = 8'h48;
	localparam logic [7:0] R_OFLIM = 8'h4C;
	localparam logic [7:0] R_DELAY = 8'h50;
	localparam logic [7:0] R_FLAGS = 8'h54;
	// Control fields
	localparam int C_FORCE = 0;
	localparam int C_CLR = 1;
	localparam int C_REF = 4;
	localparam int C_GRP = 8;
	localparam int C_RSTG = 12;
	// Direction modes and status codes
	localparam logic [1:0] MODE_RISE = 2'h0;
	localparam logic [1:0] MODE_FALL = 2'h1;
	localparam logic [1:0] ST_CODE_START = 2'h1;
	localparam logic [1:0] ST_CODE_TRIP = 2'h2;
	localparam logic [1:0] ST_CODE_BLK = 2'h3;
	typedef enum logic [3:0] {
		ST_NORMAL  = 4'h1,
		ST_START   = 4'h2,
		ST_TRIP    = 4'h4,
		ST_BLOCKED = 4'h8
	} rcf_state_t;
endpackage

// ===== hw/rcf_rocof_stages.sv
// Eight-stage rate-of-change-of-frequency element with Avalon-MM registers
//
// Our own choices: the register offsets and the Avalon-MM slave port.
module rcf_rocof_stages #(
	parameter int TICK_DIV = rcf_pkg::TICK_CYCLES,
	parameter int MS_DIV   = rcf_pkg::MS_CYCLES
) (
	input  wire logic        core_clk_i,
	input  wire logic        rst_i,
	input  wire logic [7:0]  address_i,
	input  wire logic        read_i,
	input  wire logic        write_i,
	input  wire logic [31:0] writedata_i,
	output logic [31:0]      readdata_o,
	output logic             waitrequest_o,
	input  wire logic [15:0] slope_i,
	input  wire logic [15:0] freq_ref1_i,
	input  wire logic [15:0] freq_ref2_i,
	input  wire logic [15:0] freq_ref3_i,
	input  wire logic [47:0] vt_a_phase_voltages_i,
	input  wire logic [47:0] vt_b_phase_voltages_i,
	input  wire logic [7:0]  ext_block_i,
	output logic [7:0]       start_o,
	output logic [7:0]       trip_o,
	output logic [7:0]       blocked_o,
	output logic             ev_valid_o,
	output logic [2:0]       ev_stage_o,
	output logic [1:0]       ev_kind_o,
	output logic             ev_on_o,
	output logic [31:0]      ev_time_o
);
	localparam int NS = rcf_pkg::NSTAGE;
	localparam int NE = 3 * NS;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	logic [17:0] tick_cnt_r;
	logic [15:0] ms_div_r;
	logic [31:0] ms_cnt_r, ts_hold_r;
	logic        tick_r, ms_tick;
	logic [15:0] ctrl_r, maxrate_r, en_r, force_r, grp_sel_r;
	logic [15:0] slope_r, freq_r, mag_r;
	logic [31:0] volt_r, cnt_start_r, cnt_trip_r, cnt_blk_r;
	logic [31:0] readdata_nxt;
	logic        over_r, req, acc;
	logic [15:0] pick_mem [64];
	logic [15:0] uf_mem [64];
	logic [15:0] of_mem [64];
	logic [18:0] dly_mem [64];
	logic [3:0]  flg_mem [64];
	rcf_pkg::rcf_state_t st_r [NS];
	logic [18:0] cnt_r [NS];
	logic [NS-1:0] picked_r, blk_r;
	logic [NE-1:0] out_all, posted_r;
	logic [4:0]  scan_r;
	logic [31:0] log_time [rcf_pkg::LOG_DEPTH];
	logic [7:0]  log_info [rcf_pkg::LOG_DEPTH];
	logic [3:0]  log_wp_r, log_sel_r;
	logic [15:0] ratio_r;
	// Status code of a stage state
	function automatic logic [1:0] st_code(input rcf_pkg::rcf_state_t s);
		case (s)
			rcf_pkg::ST_START:   st_code = rcf_pkg::ST_CODE_START;
			rcf_pkg::ST_TRIP:    st_code = rcf_pkg::ST_CODE_TRIP;
			rcf_pkg::ST_BLOCKED: st_code = rcf_pkg::ST_CODE_BLK;
			default:             st_code = 2'h0;
		endcase
	endfunction
	// Setting memory index of one stage in one group
	function automatic logic [5:0] sidx(input logic [2:0] g, input logic [2:0] s);
		sidx = {g, s};
	endfunction
	assign req = read_i | write_i;
	assign acc = req & ~waitrequest_o;
	assign ms_tick = (ms_div_r == 16'(MS_DIV - 1));
	// Program cycle divider and millisecond stamp
	// stamp counter
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			tick_cnt_r <= 18'h00000;
			tick_r <= 1'b0;
			ms_div_r <= 16'h0000;
			ms_cnt_r <= 32'h00000000;
		end else begin
			tick_r <= (tick_cnt_r == 18'(TICK_DIV - 1));
			tick_cnt_r <= (tick_cnt_r == 18'(TICK_DIV - 1)) ? 18'h00000 : tick_cnt_r + 18'h00001;
			ms_div_r <= ms_tick ? 16'h0000 : ms_div_r + 16'h0001;
			ms_cnt_r <= ms_cnt_r + {31'h00000000, ms_tick};
		end
	end
	// Input sampling once per program cycle
	// reference pick, voltage time base, block sampling
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			{slope_r, mag_r, freq_r} <= 48'h000000000000;
			volt_r <= 32'h00000000;
			blk_r <= 8'h00;
			over_r <= 1'b0;
		end else if (tick_r) begin
			slope_r <= slope_i;
			mag_r <= slope_i[15] ? 16'(-slope_i) : slope_i;
			case (ctrl_r[rcf_pkg::C_REF +: 2])
				2'h1: begin
					freq_r <= freq_ref2_i;
					volt_r <= {vt_b_phase_voltages_i[31:16], vt_a_phase_voltages_i[31:16]};
				end
				2'h2: begin
					freq_r <= freq_ref3_i;
					volt_r <= {vt_b_phase_voltages_i[47:32], vt_a_phase_voltages_i[47:32]};
				end
				default: begin
					freq_r <= freq_ref1_i;
					volt_r <= {vt_b_phase_voltages_i[15:0], vt_a_phase_voltages_i[15:0]};
				end
			endcase
			over_r <= ((slope_i[15] ? 16'(-slope_i) : slope_i) > maxrate_r);
			blk_r <= ext_block_i;
		end
	end
	// Per-stage pick-up, blocking and delay
	for (genvar i = 0; i < NS; i++) begin : g_stage
		logic [5:0]  ix;
		logic        active, dir_ok, gate_ok, cond, pick_nxt, blk;
		logic [15:0] rel;
		assign ix = sidx(ctrl_r[rcf_pkg::C_GRP +: 3], 3'(i));
		assign active = (en_r[2*i +: 2] == rcf_pkg::EN_YES) & flg_mem[ix][0];
		assign dir_ok = (~slope_r[15] & (slope_r != 16'h0000)
			& (flg_mem[ix][2:1] != rcf_pkg::MODE_FALL))
			| (slope_r[15] & (flg_mem[ix][2:1] != rcf_pkg::MODE_RISE));
		// gate select, under limit, over limit
		assign gate_ok = ~flg_mem[ix][3]
			| (~slope_r[15] & (freq_r > of_mem[ix]))
			| (slope_r[15] & (freq_r < uf_mem[ix]));
		assign cond = active & dir_ok & gate_ok;
		assign rel = (pick_mem[ix] > rcf_pkg::HYST) ? pick_mem[ix] - rcf_pkg::HYST : 16'h0000;
		assign pick_nxt = cond & (mag_r >= (picked_r[i] ? rel : pick_mem[ix]));
		assign blk = blk_r[i] | over_r;
		always_ff @(posedge core_clk_i or posedge rst_i) begin
			if (rst_i) begin
				picked_r[i] <= 1'b0;
				st_r[i] <= rcf_pkg::ST_NORMAL;
				cnt_r[i] <= 19'h00000;
			end else if (tick_r) begin
				picked_r[i] <= pick_nxt;
				case (st_r[i])
					rcf_pkg::ST_NORMAL: begin
						if (pick_nxt && blk) begin
							st_r[i] <= rcf_pkg::ST_BLOCKED;
						end else if (pick_nxt) begin
							st_r[i] <= (dly_mem[ix] == 19'h00000) ? rcf_pkg::ST_TRIP
								: rcf_pkg::ST_START;
							cnt_r[i] <= 19'h00001;
						end
					end
					rcf_pkg::ST_START, rcf_pkg::ST_TRIP: begin
						if (!pick_nxt) begin
							st_r[i] <= rcf_pkg::ST_NORMAL;
						end else if (blk) begin
							st_r[i] <= rcf_pkg::ST_BLOCKED;
						end else if (st_r[i] == rcf_pkg::ST_START) begin
							cnt_r[i] <= cnt_r[i] + 19'h00001;
							if (cnt_r[i] >= dly_mem[ix]) begin
								st_r[i] <= rcf_pkg::ST_TRIP;
							end
						end
					end
					rcf_pkg::ST_BLOCKED: begin
						if (!pick_nxt) begin
							st_r[i] <= rcf_pkg::ST_NORMAL;
						end
					end
					default: st_r[i] <= rcf_pkg::ST_NORMAL;
				endcase
			end
		end
		// Stage outputs, forced status overriding
		// outputs, forcing
		always_ff @(posedge core_clk_i or posedge rst_i) begin
			if (rst_i) begin
				{start_o[i], trip_o[i], blocked_o[i]} <= 3'h0;
			end else begin
				logic [1:0] c;
				c = ctrl_r[rcf_pkg::C_FORCE] ? force_r[2*i +: 2] : st_code(st_r[i]);
				start_o[i] <= (c == rcf_pkg::ST_CODE_START) | (c == rcf_pkg::ST_CODE_TRIP);
				trip_o[i] <= (c == rcf_pkg::ST_CODE_TRIP);
				blocked_o[i] <= (c == rcf_pkg::ST_CODE_BLK);
			end
		end
		a_block_at_pick: assert property (
			tick_r && st_r[i] == rcf_pkg::ST_NORMAL && pick_nxt && blk
			|=> st_r[i] == rcf_pkg::ST_BLOCKED) else $error("blocked pick-up started");
		a_delay_expiry: assert property (
			tick_r && st_r[i] == rcf_pkg::ST_START && pick_nxt && !blk
			&& cnt_r[i] >= dly_mem[ix] |=> st_r[i] == rcf_pkg::ST_TRIP)
			else $error("delay expiry missed");
		a_over_rate: assert property (
			tick_r && over_r && pick_nxt |=> st_r[i] != rcf_pkg::ST_START)
			else $error("started during over-rate");
		a_hyst_hold: assert property (
			tick_r && picked_r[i] && cond && mag_r >= rel && mag_r < pick_mem[ix]
			|=> picked_r[i]) else $error("released inside hysteresis");
		a_stage_off: assert property (
			tick_r && !active |=> !picked_r[i]) else $error("disabled stage picked up");
	end
	assign out_all = {blocked_o, trip_o, start_o};
	// Event scan posting each output change with a held stamp
	// change events, shared stamp
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			scan_r <= 5'h00;
			posted_r <= '0;
			ts_hold_r <= 32'h00000000;
			ev_valid_o <= 1'b0;
			{ev_stage_o, ev_kind_o, ev_on_o} <= 6'h00;
			ev_time_o <= 32'h00000000;
		end else begin
			scan_r <= (scan_r == 5'(NE - 1)) ? 5'h00 : scan_r + 5'h01;
			if (posted_r == out_all) begin
				ts_hold_r <= ms_cnt_r;
			end
			ev_valid_o <= (posted_r[scan_r] != out_all[scan_r]);
			ev_stage_o <= scan_r[2:0];
			ev_kind_o <= scan_r[4:3];
			ev_on_o <= out_all[scan_r];
			ev_time_o <= ts_hold_r;
			posted_r[scan_r] <= out_all[scan_r];
		end
	end
	// Record ring of the last events, oldest overwritten
	// twelve records
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			log_wp_r <= 4'h0;
			for (int k = 0; k < rcf_pkg::LOG_DEPTH; k++) begin
				log_time[k] <= 32'h00000000;
				log_info[k] <= 8'h00;
			end
		end else if (ev_valid_o) begin
			log_time[log_wp_r] <= ev_time_o;
			log_info[log_wp_r] <= {ctrl_r[rcf_pkg::C_GRP +: 2], ev_on_o, ev_kind_o, ev_stage_o};
			log_wp_r <= (log_wp_r == 4'(rcf_pkg::LOG_DEPTH - 1)) ? 4'h0 : log_wp_r + 4'h1;
		end
	end
	// Cumulative counters, clear applies first and a same-cycle event still counts
	// counters
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			{cnt_start_r, cnt_trip_r, cnt_blk_r} <= 96'h000000000000000000000000;
		end else begin
			logic clr, on;
			clr = acc & write_i & (address_i == rcf_pkg::R_CTRL) & writedata_i[rcf_pkg::C_CLR];
			on = ev_valid_o & ev_on_o;
			cnt_start_r <= (clr ? 32'h00000000 : cnt_start_r)
				+ {31'h00000000, on & (ev_kind_o == 2'h0)};
			cnt_trip_r <= (clr ? 32'h00000000 : cnt_trip_r)
				+ {31'h00000000, on & (ev_kind_o == 2'h1)};
			cnt_blk_r <= (clr ? 32'h00000000 : cnt_blk_r)
				+ {31'h00000000, on & (ev_kind_o == 2'h2)};
		end
	end
	// Measured-to-setting ratio of the chosen stage, in thousandths
	// ratio
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ratio_r <= 16'h0000;
		end else if (tick_r) begin
			logic [5:0] rx;
			rx = sidx(ctrl_r[rcf_pkg::C_GRP +: 3], ctrl_r[rcf_pkg::C_RSTG +: 3]);
			ratio_r <= (pick_mem[rx] == 16'h0000) ? 16'h0000
				: 16'(({16'h0000, mag_r} * {22'h000000, rcf_pkg::RATIO_SCALE})
				/ {16'h0000, pick_mem[rx]});
		end
	end
	// Avalon slave: one wait cycle, then accepted
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			waitrequest_o <= 1'b1;
			readdata_o <= 32'h00000000;
		end else begin
			waitrequest_o <= ~(req & waitrequest_o);
			if (req && waitrequest_o) begin
				readdata_o <= read_i ? readdata_nxt : 32'h00000000;
			end
		end
	end
	// Register writes
	// group selection
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ctrl_r <= 16'h0000;
			maxrate_r <= rcf_pkg::MAXRATE_RST;
			en_r <= rcf_pkg::EN_RST;
			force_r <= 16'h0000;
			grp_sel_r <= 16'h0000;
			log_sel_r <= 4'h0;
			for (int k = 0; k < 64; k++) begin
				pick_mem[k] <= rcf_pkg::PICK_RST;
				uf_mem[k] <= rcf_pkg::UFLIM_RST;
				of_mem[k] <= rcf_pkg::OFLIM_RST;
				dly_mem[k] <= rcf_pkg::DLY_RST;
				flg_mem[k] <= 4'h0;
			end
		end else if (acc && write_i) begin
			case (address_i)
				rcf_pkg::R_CTRL:    ctrl_r <= writedata_i[15:0] & 16'h7731;
				rcf_pkg::R_MAXRATE: maxrate_r <= writedata_i[15:0];
				rcf_pkg::R_ENABLE:  en_r <= writedata_i[15:0];
				rcf_pkg::R_FORCE:   force_r <= writedata_i[15:0];
				rcf_pkg::R_GRP_SEL: grp_sel_r <= {10'h000, writedata_i[5:0]};
				rcf_pkg::R_LOG_SEL: log_sel_r <= writedata_i[3:0];
				rcf_pkg::R_PICK:    pick_mem[grp_sel_r[5:0]] <= writedata_i[15:0];
				rcf_pkg::R_UFLIM:   uf_mem[grp_sel_r[5:0]] <= writedata_i[15:0];
				rcf_pkg::R_OFLIM:   of_mem[grp_sel_r[5:0]] <= writedata_i[15:0];
				rcf_pkg::R_DELAY:   dly_mem[grp_sel_r[5:0]] <= (writedata_i[18:0] > rcf_pkg::DLY_MAX)
					? rcf_pkg::DLY_MAX : writedata_i[18:0];
				rcf_pkg::R_FLAGS:   flg_mem[grp_sel_r[5:0]] <= writedata_i[3:0];
				default: ;
			endcase
		end
	end
	// Read multiplexer; unmapped offsets read zero
	always_comb begin
		logic [5:0] g;
		g = grp_sel_r[5:0];
		case (address_i)
			rcf_pkg::R_CTRL:      readdata_nxt = {16'h0000, ctrl_r & 16'h7731};
			rcf_pkg::R_MAXRATE:   readdata_nxt = {16'h0000, maxrate_r};
			rcf_pkg::R_ENABLE:    readdata_nxt = {16'h0000, en_r};
			rcf_pkg::R_FORCE:     readdata_nxt = {16'h0000, force_r};
			rcf_pkg::R_STATUS:    readdata_nxt = {7'h00, over_r, blocked_o, trip_o, start_o};
			rcf_pkg::R_CNT_START: readdata_nxt = cnt_start_r;
			rcf_pkg::R_CNT_TRIP:  readdata_nxt = cnt_trip_r;
			rcf_pkg::R_CNT_BLK:   readdata_nxt = cnt_blk_r;
			rcf_pkg::R_RATIO:     readdata_nxt = {16'h0000, ratio_r};
			rcf_pkg::R_VOLT:      readdata_nxt = volt_r;
			rcf_pkg::R_LOG_SEL:   readdata_nxt = {24'h000000, log_wp_r, log_sel_r};
			rcf_pkg::R_LOG_INFO:  readdata_nxt = (log_sel_r < 4'(rcf_pkg::LOG_DEPTH))
				? {24'h000000, log_info[log_sel_r]} : 32'h00000000;
			rcf_pkg::R_LOG_TIME:  readdata_nxt = (log_sel_r < 4'(rcf_pkg::LOG_DEPTH))
				? log_time[log_sel_r] : 32'h00000000;
			rcf_pkg::R_GRP_SEL:   readdata_nxt = {16'h0000, grp_sel_r};
			rcf_pkg::R_PICK:      readdata_nxt = {16'h0000, pick_mem[g]};
			rcf_pkg::R_UFLIM:     readdata_nxt = {16'h0000, uf_mem[g]};
			rcf_pkg::R_OFLIM:     readdata_nxt = {16'h0000, of_mem[g]};
			rcf_pkg::R_DELAY:     readdata_nxt = {13'h0000, dly_mem[g]};
			rcf_pkg::R_FLAGS:     readdata_nxt = {28'h0000000, flg_mem[g]};
			default:              readdata_nxt = 32'h00000000;
		endcase
	end
	sequence s_force_trip;
		ctrl_r[rcf_pkg::C_FORCE] && force_r[1:0] == rcf_pkg::ST_CODE_TRIP;
	endsequence
	sequence s_clear_quiet;
		acc && write_i && address_i == rcf_pkg::R_CTRL && writedata_i[rcf_pkg::C_CLR]
		&& !ev_valid_o;
	endsequence
	a_forced_trip: assert property (
		s_force_trip |=> trip_o[0] && start_o[0] && !blocked_o[0]) else $error("force ignored");
	a_event_posted: assert property (
		posted_r != out_all |-> ##[1:24] ev_valid_o) else $error("change not posted");
	a_count_clear: assert property (
		s_clear_quiet |=> cnt_start_r == 32'h00000000 && cnt_trip_r == 32'h00000000)
		else $error("counter clear lost");
	a_ms_stamp: assert property (
		ms_tick |=> ms_cnt_r == $past(ms_cnt_r) + 32'h00000001) else $error("stamp step wrong");
	a_bus_answer: assert property (
		req && waitrequest_o |=> !waitrequest_o ##1 waitrequest_o) else $error("bus answer late");
endmodule

// ===== dv/rcf_front_model.sv
// Behavioural frequency front end and blocking matrix feeding the stages
module rcf_front_model (
	input  wire logic        core_clk_i,
	input  wire logic [15:0] slope_set_i,
	input  wire logic [15:0] freq_set_i,
	input  wire logic [7:0]  blk_set_i,
	output logic [15:0]      slope_o,
	output logic [15:0]      f1_o,
	output logic [15:0]      f2_o,
	output logic [15:0]      f3_o,
	output logic [47:0]      va_o,
	output logic [47:0]      vb_o,
	output logic [7:0]       blk_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] cnt_r = 16'h0000;
	// Measurements refresh every cycle, voltages never sit still
	always @(posedge core_clk_i) begin
		cnt_r <= cnt_r + 16'h0001;
		slope_o <= slope_set_i;
		f1_o <= freq_set_i;
		f2_o <= 16'h1388;
		f3_o <= 16'h1388;
		// voltage channels per cycle, phase number in the top bits
		va_o <= {3'h3, cnt_r[12:0], 3'h2, cnt_r[12:0], 3'h1, cnt_r[12:0]};
		vb_o <= ~{3'h3, cnt_r[12:0], 3'h2, cnt_r[12:0], 3'h1, cnt_r[12:0]};
		blk_o <= blk_set_i;
	end
endmodule

// ===== dv/rcf_rocof_stages_tb.sv
// Self-checking bench for the rate-of-change-of-frequency stages
module rcf_rocof_stages_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TD = 64;
	logic        core_clk_i = 1'b0;
	logic        rst_i      = 1'b1;
	logic [7:0]  bus_addr   = 8'h00;
	logic        bus_rd     = 1'b0;
	logic        bus_wr     = 1'b0;
	logic [31:0] bus_wdata  = 32'h0;
	logic [15:0] slope_set  = 16'h0000;
	logic [15:0] freq_set   = 16'h1388;
	logic [7:0]  blk_set    = 8'h00;
	logic [31:0] readdata_o, ev_time_o, rdata;
	logic        waitrequest_o, ev_valid_o, ev_on_o;
	logic [7:0]  start_o, trip_o, blocked_o, blk_w;
	logic [2:0]  ev_stage_o;
	logic [1:0]  ev_kind_o;
	logic [15:0] slope_w, f1_w, f2_w, f3_w;
	logic [47:0] va_w, vb_w;
	logic [31:0] ev_time [0:3][0:1];
	int          num_errors = 0;
	int          n_tests = 0;
	int          ev_cnt = 0;
	int          n0;
	int          i;
	logic [7:0]  raddr [0:6] = '{rcf_pkg::R_MAXRATE, rcf_pkg::R_ENABLE, rcf_pkg::R_PICK,
		rcf_pkg::R_UFLIM, rcf_pkg::R_OFLIM, rcf_pkg::R_DELAY, 8'h3C};
	logic [31:0] rexp [0:6] = '{32'h7D0, 32'h5555, 32'h14, 32'h1383, 32'h13EC, 32'h14, 32'h0};

	rcf_front_model fm (.core_clk_i(core_clk_i), .slope_set_i(slope_set), .freq_set_i(freq_set),
		.blk_set_i(blk_set), .slope_o(slope_w), .f1_o(f1_w), .f2_o(f2_w), .f3_o(f3_w),
		.va_o(va_w), .vb_o(vb_w), .blk_o(blk_w));
	rcf_rocof_stages #(.TICK_DIV(TD), .MS_DIV(8)) dut (.core_clk_i(core_clk_i), .rst_i(rst_i),
		.address_i(bus_addr), .read_i(bus_rd), .write_i(bus_wr), .writedata_i(bus_wdata),
		.readdata_o(readdata_o), .waitrequest_o(waitrequest_o), .slope_i(slope_w),
		.freq_ref1_i(f1_w), .freq_ref2_i(f2_w), .freq_ref3_i(f3_w),
		.vt_a_phase_voltages_i(va_w), .vt_b_phase_voltages_i(vb_w), .ext_block_i(blk_w),
		.start_o(start_o), .trip_o(trip_o), .blocked_o(blocked_o), .ev_valid_o(ev_valid_o),
		.ev_stage_o(ev_stage_o), .ev_kind_o(ev_kind_o), .ev_on_o(ev_on_o), .ev_time_o(ev_time_o));

	// Clock at 40 MHz
	always #12.5 core_clk_i = ~core_clk_i;

	// Stage 0 event monitor keeps the latest stamp per kind and polarity
	initial begin
		for (int k = 0; k < 4; k++) begin
			ev_time[k][0] = 32'h0;
			ev_time[k][1] = 32'h0;
		end
	end
	always @(posedge core_clk_i) begin
		if (ev_valid_o === 1'b1 && ev_stage_o === 3'h0) begin
			ev_time[ev_kind_o][ev_on_o] <= ev_time_o;
			ev_cnt <= ev_cnt + 1;
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Compares stage 0 {start, trip, blocked}
	task automatic outs(input logic [2:0] exp);
		chk({29'h0, start_o[0], trip_o[0], blocked_o[0]}, {29'h0, exp});
	endtask

	// Avalon write, held until waitrequest is sampled low
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk_i);
		bus_addr <= a;
		bus_wdata <= d;
		bus_wr <= 1'b1;
		@(posedge core_clk_i);
		while (waitrequest_o !== 1'b0) begin
			@(posedge core_clk_i);
		end
		bus_wr <= 1'b0;
	endtask

	// Avalon read, data taken at the accepting edge
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge core_clk_i);
		bus_addr <= a;
		bus_rd <= 1'b1;
		@(posedge core_clk_i);
		while (waitrequest_o !== 1'b0) begin
			@(posedge core_clk_i);
		end
		d = readdata_o;
		bus_rd <= 1'b0;
	endtask

	task automatic tick(input int n);
		repeat (n * TD) @(posedge core_clk_i);
	endtask

	task automatic wrap_up;
		$display("tests=%0d errors=%0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Watchdog well beyond the expected run length
	initial begin
		repeat (40000) @(posedge core_clk_i);
		num_errors++;
		wrap_up();
	end

	initial begin
		repeat (10) @(posedge core_clk_i);
		rst_i <= 1'b0;
		for (i = 0; i < 7; i++) begin
			rd(raddr[i], rdata);
			chk(rdata, rexp[i]);
		end
		// Stage 0, group 0: used, both directions, instant
		wr(rcf_pkg::R_GRP_SEL, 32'h0);
		wr(rcf_pkg::R_FLAGS, 32'h5);
		wr(rcf_pkg::R_DELAY, 32'h0);
		slope_set <= 16'h0064;
		tick(3);
		outs(3'b000);
		n0 = ev_cnt;
		wr(rcf_pkg::R_ENABLE, 32'h5556);
		tick(3);
		outs(3'b110);
		chk(32'(ev_cnt - n0), 32'h2);
		chk(ev_time[1][1], ev_time[0][1]);
		// Release with fixed hysteresis below pick-up
		slope_set <= 16'h000F;
		tick(3);
		outs(3'b110);
		slope_set <= 16'h0009;
		tick(3);
		outs(3'b000);
		chk(32'(ev_cnt - n0), 32'h4);
		// Direction modes on a falling slope, then the unused group 1 settings
		slope_set <= 16'hFF9C;
		tick(3);
		outs(3'b110);
		wr(rcf_pkg::R_FLAGS, 32'h1);
		tick(3);
		outs(3'b000);
		wr(rcf_pkg::R_FLAGS, 32'h3);
		tick(3);
		outs(3'b110);
		wr(rcf_pkg::R_CTRL, 32'h100);
		tick(3);
		outs(3'b000);
		slope_set <= 16'h0000;
		wr(rcf_pkg::R_CTRL, 32'h0);
		// Definite delay of four ticks
		wr(rcf_pkg::R_FLAGS, 32'h5);
		wr(rcf_pkg::R_DELAY, 32'h4);
		tick(3);
		slope_set <= 16'h0064;
		tick(3);
		outs(3'b100);
		rd(rcf_pkg::R_RATIO, rdata);
		chk(rdata, 32'h1388);
		tick(5);
		outs(3'b110);
		// Block after trip, then block at pick-up
		blk_set <= 8'h01;
		tick(3);
		chk({31'h0, start_o[0]}, 32'h0);
		slope_set <= 16'h0000;
		tick(3);
		slope_set <= 16'h0064;
		tick(3);
		outs(3'b001);
		blk_set <= 8'h00;
		slope_set <= 16'h0000;
		tick(3);
		// Over-rate blocks
		slope_set <= 16'h0834;
		tick(3);
		outs(3'b001);
		rd(rcf_pkg::R_STATUS, rdata);
		chk({31'h0, rdata[24]}, 32'h1);
		slope_set <= 16'h0000;
		tick(3);
		// Frequency permission gates
		wr(rcf_pkg::R_DELAY, 32'h0);
		wr(rcf_pkg::R_FLAGS, 32'hB);
		slope_set <= 16'hFF9C;
		tick(3);
		chk({31'h0, trip_o[0]}, 32'h0);
		freq_set <= 16'h1324;
		tick(3);
		chk({31'h0, trip_o[0]}, 32'h1);
		// Reference 2 sits at nominal frequency and carries phase 2 voltages
		wr(rcf_pkg::R_CTRL, 32'h10);
		tick(3);
		chk({31'h0, trip_o[0]}, 32'h0);
		rd(rcf_pkg::R_VOLT, rdata);
		chk({29'h0, rdata[15:13]}, 32'h2);
		chk({16'h0, rdata[31:16]}, {16'h0, ~rdata[15:0]});
		wr(rcf_pkg::R_CTRL, 32'h0);
		wr(rcf_pkg::R_FLAGS, 32'h9);
		slope_set <= 16'h0064;
		freq_set <= 16'h13BA;
		tick(3);
		chk({31'h0, trip_o[0]}, 32'h0);
		freq_set <= 16'h1450;
		tick(3);
		chk({31'h0, trip_o[0]}, 32'h1);
		slope_set <= 16'h0000;
		freq_set <= 16'h1388;
		tick(3);
		// Forcing needs the permission bit
		wr(rcf_pkg::R_FORCE, 32'h2);
		repeat (4) @(posedge core_clk_i);
		outs(3'b000);
		wr(rcf_pkg::R_CTRL, 32'h1);
		repeat (4) @(posedge core_clk_i);
		chk({31'h0, trip_o[0]}, 32'h1);
		wr(rcf_pkg::R_CTRL, 32'h0);
		wr(rcf_pkg::R_FORCE, 32'h0);
		tick(2);
		// Counters hold history, then clear
		rd(rcf_pkg::R_CNT_START, rdata);
		chk({31'h0, rdata != 32'h0}, 32'h1);
		wr(rcf_pkg::R_CTRL, 32'h2);
		for (i = 0; i < 3; i++) begin
			rd(rcf_pkg::R_CNT_START + 8'(4 * i), rdata);
			chk(rdata, 32'h0);
		end
		// Every stage 0 event lands in the ring
		rd(rcf_pkg::R_LOG_SEL, rdata);
		chk({28'h0, rdata[7:4]}, 32'(ev_cnt % rcf_pkg::LOG_DEPTH));
		wrap_up();
	end
endmodule
